// *** core/twmr_regs.svh ***
// register map, field positions, status codes and timing for the receiver
`ifndef TWMR_REGS_SVH
`define TWMR_REGS_SVH
`define TWMR_A_CTRL   2'h0
`define TWMR_A_STAT   2'h1
`define TWMR_A_DATA   2'h2
`define TWMR_B_FLAG   7
`define TWMR_B_WCOL   3
`define TWMR_B_EN     2
`define TWMR_B_ACK    6
`define TWMR_B_BEGIN  5
`define TWMR_B_HALT   4
`define TWMR_B_IE     0
`define TWMR_CTRL_RST 8'h00
`define TWMR_DATA_RST 8'hff
`define TWMR_S_START  8'h08
`define TWMR_S_RSTART 8'h10
`define TWMR_S_WACK   8'h18
`define TWMR_S_WNACK  8'h20
`define TWMR_S_LOST   8'h38
`define TWMR_S_RACK   8'h40
`define TWMR_S_RNACK  8'h48
`define TWMR_S_DACK   8'h50
`define TWMR_S_DNACK  8'h58
`define TWMR_S_NONE   8'hf8
`define TWMR_CLK_NS   8
`define TWMR_QTR_NS   625
`define TWMR_QTR_CYC  ((`TWMR_QTR_NS + `TWMR_CLK_NS - 1) / `TWMR_CLK_NS)
`define TWMR_PH_LAST  2'h3
`define TWMR_PH_HIGH  2'h2
`define TWMR_BIT_LAST 3'h7
`endif

// *** core/twmr_pkg.sv ***
// types shared by the two-wire master receiver
package twmr_pkg;
	typedef enum logic [8:0] {
		TWMR_IDLE   = 9'h001,
		TWMR_WAIT   = 9'h002,
		TWMR_START  = 9'h004,
		TWMR_ADDR   = 9'h008,
		TWMR_ACKIN  = 9'h010,
		TWMR_RX     = 9'h020,
		TWMR_ACKOUT = 9'h040,
		TWMR_HOLD   = 9'h080,
		TWMR_STOP   = 9'h100
	} twmr_state_t;
	typedef struct packed {
		logic flag;
		logic ack_en;
		logic begin_req;
		logic halt_req;
		logic wcol;
		logic enable;
		logic rsvd;
		logic int_en;
	} twmr_ctrl_t;
endpackage

// *** core/twmr_core.sv ***
// two-wire master receiver with its control, status and data registers
//
// The address map and strobed register access were decided locally.
`include "twmr_regs.svh"
// Notes on behaviour
// RL1 - software sends START first; address direction bit picks receive or transmit; here a write address reports 18 or 20 and no transmit follows
// RL2 - status codes read with prescaler bits zero; software masks them
// RL3 - START request: flag 1, begin 1, halt 0, enable 1
// RL4 - disabled unless enable is one; writing flag one clears it, resuming
// RL5 - START only issued once the bus is free; never break a transfer
// RL6 - after START the flag sets with code 08; software loads address
// RL7 - software loads data first, then resumes with no condition requests
// RL8 - after read address and acknowledge, flag sets with 38, 40 or 48
// RL9 - code 38 then plain resume releases the bus, unaddressed
// RL10 - code 38 then begin request waits for free bus, sends START
// RL11 - from 40 or 50 receive a byte; ACK if ack enable else NACK
// RL12 - after a byte code 50 on ACK, 58 on NACK; byte readable
// RL13 - software reads each byte while the flag is set, before clearing
// RL14 - after 48 only repeated START, STOP, or STOP then START accepted
// RL15 - software clears ack enable before the last byte to NACK it
// RL16 - STOP request: flag 1, begin 0, halt 1, enable 1
// RL17 - sent STOP clears halt bit; begin and halt give STOP then START
// RL18 - repeated START reports 10 and keeps the bus
// RL19 - from 10 read address stays receive; write address goes transmit; here 18 or 20 is reported and only a condition request is taken
// RL20 - clock held low while the flag is set; here only while the bus is owned, so not after code 38
module twmr_core (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [1:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oen,
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oen
);
	twmr_pkg::twmr_ctrl_t  ctrl_reg;
	twmr_pkg::twmr_state_t st_reg;
	logic [7:0] code_reg;
	logic [1:0] pre_reg;
	logic [7:0] data_reg;
	logic [7:0] sh_reg;
	logic [2:0] bit_reg;
	logic [1:0] ph_reg;
	logic [6:0] q_reg;
	logic       owner_reg;
	logic       rd_mode_reg;
	logic [2:0] sda_s_reg;
	logic [2:0] scl_s_reg;
	logic       sda_f_reg;
	logic       scl_f_reg;
	logic       sda_p_reg;
	logic       busy_reg;
	logic       set_flag;
	logic [7:0] new_code;
	logic       step_done;
	logic       tick;
	logic       scl_low;
	logic       sda_low;
	logic       wr_ctrl;
	logic       wr_data;
	logic       refuse;
	logic       halt_done;
	logic       lost;

	assign wr_ctrl = reg_wr && reg_addr == `TWMR_A_CTRL;
	assign wr_data = reg_wr && reg_addr == `TWMR_A_DATA;
	assign tick = q_reg == 7'(`TWMR_QTR_CYC - 1);
	assign step_done = tick && ph_reg == `TWMR_PH_LAST;
	assign halt_done = st_reg == twmr_pkg::TWMR_STOP && step_done;
	// codes 18, 20, 48 and 58 accept only a condition request
	assign refuse = !reg_wdata[`TWMR_B_BEGIN] && !reg_wdata[`TWMR_B_HALT] &&
		(code_reg == `TWMR_S_RNACK || code_reg == `TWMR_S_DNACK ||
		 code_reg == `TWMR_S_WACK || code_reg == `TWMR_S_WNACK); // RL14

	// pin sampling: three stages, a change counts when stages two and three agree
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sda_s_reg <= 3'h7;
			scl_s_reg <= 3'h7;
			sda_f_reg <= 1'b1;
			scl_f_reg <= 1'b1;
			sda_p_reg <= 1'b1;
		end else begin
			sda_s_reg <= {sda_s_reg[1:0], sda_i};
			scl_s_reg <= {scl_s_reg[1:0], scl_i};
			if (sda_s_reg[1] == sda_s_reg[2])
				sda_f_reg <= sda_s_reg[2];
			if (scl_s_reg[1] == scl_s_reg[2])
				scl_f_reg <= scl_s_reg[2];
			sda_p_reg <= sda_f_reg;
		end
	end

	// bus busy between any START and STOP seen on the wires
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			busy_reg <= 1'b0;
		else if (scl_f_reg && sda_p_reg && !sda_f_reg)
			busy_reg <= 1'b1;
		else if (scl_f_reg && !sda_p_reg && sda_f_reg)
			busy_reg <= 1'b0;
	end

	// line drive per state and quarter phase
	always_comb begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		case (st_reg)
			twmr_pkg::TWMR_START: begin
				scl_low = (ph_reg == 2'h0 && owner_reg) || ph_reg == `TWMR_PH_LAST;
				sda_low = ph_reg[1];
			end
			twmr_pkg::TWMR_ADDR: begin
				scl_low = !ph_reg[1];
				sda_low = !sh_reg[7];
			end
			twmr_pkg::TWMR_ACKIN, twmr_pkg::TWMR_RX:
				scl_low = !ph_reg[1];
			twmr_pkg::TWMR_ACKOUT: begin
				scl_low = !ph_reg[1];
				sda_low = ctrl_reg.ack_en; // RL11
			end
			twmr_pkg::TWMR_HOLD:
				scl_low = owner_reg; // RL20
			twmr_pkg::TWMR_STOP: begin
				scl_low = ph_reg == 2'h0;
				sda_low = !ph_reg[1];
			end
			default: begin
				scl_low = 1'b0;
				sda_low = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			scl_oen <= 1'b1;
			sda_oen <= 1'b1;
			scl_o   <= 1'b0;
			sda_o   <= 1'b0;
		end else begin
			scl_oen <= !scl_low;
			sda_oen <= !sda_low;
		end
	end

	// quarter-bit timer; outside START and STOP the high phase waits while a slave stretches the clock
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			q_reg  <= 7'h00;
			ph_reg <= 2'h0;
		end else if (st_reg == twmr_pkg::TWMR_IDLE || st_reg == twmr_pkg::TWMR_WAIT ||
			st_reg == twmr_pkg::TWMR_HOLD) begin
			q_reg  <= 7'h00;
			ph_reg <= 2'h0;
		end else if (ph_reg == `TWMR_PH_HIGH && !scl_f_reg && st_reg != twmr_pkg::TWMR_STOP &&
			st_reg != twmr_pkg::TWMR_START) begin
			q_reg <= 7'h00;
		end else if (tick) begin
			q_reg  <= 7'h00;
			ph_reg <= ph_reg + 2'h1;
		end else begin
			q_reg <= q_reg + 7'h01;
		end
	end

	// lost arbitration: released high but wire read low
	always_comb begin
		lost = 1'b0;
		if (st_reg == twmr_pkg::TWMR_ADDR)
			lost = sh_reg[7] && !sda_f_reg;
		else if (st_reg == twmr_pkg::TWMR_ACKOUT)
			lost = !ctrl_reg.ack_en && !sda_f_reg; // RL9
	end

	// bus sequencer
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg      <= twmr_pkg::TWMR_IDLE;
			owner_reg   <= 1'b0;
			rd_mode_reg <= 1'b0;
			bit_reg     <= 3'h0;
			sh_reg      <= 8'h00;
			set_flag    <= 1'b0;
			new_code    <= `TWMR_S_NONE;
		end else begin
			set_flag <= 1'b0;
			if (!ctrl_reg.enable) begin
				st_reg    <= twmr_pkg::TWMR_IDLE; // RL4
				owner_reg <= 1'b0;
			end else begin
				case (st_reg)
					twmr_pkg::TWMR_IDLE:
						if (ctrl_reg.begin_req && !ctrl_reg.flag)
							st_reg <= twmr_pkg::TWMR_WAIT; // RL1
					twmr_pkg::TWMR_WAIT:
						if (!busy_reg)
							st_reg <= twmr_pkg::TWMR_START; // RL5
					twmr_pkg::TWMR_START:
						if (step_done) begin
							new_code  <= owner_reg ? `TWMR_S_RSTART : `TWMR_S_START; // RL6
							owner_reg <= 1'b1; // RL18
							set_flag  <= 1'b1;
							st_reg    <= twmr_pkg::TWMR_HOLD;
						end
					twmr_pkg::TWMR_ADDR:
						if (step_done) begin
							if (lost) begin
								new_code  <= `TWMR_S_LOST;
								owner_reg <= 1'b0;
								set_flag  <= 1'b1;
								st_reg    <= twmr_pkg::TWMR_HOLD;
							end else begin
								sh_reg  <= {sh_reg[6:0], 1'b0};
								bit_reg <= bit_reg + 3'h1;
								if (bit_reg == `TWMR_BIT_LAST)
									st_reg <= twmr_pkg::TWMR_ACKIN;
							end
						end
					twmr_pkg::TWMR_ACKIN:
						if (step_done) begin
							if (rd_mode_reg)
								new_code <= sda_f_reg ? `TWMR_S_RNACK : `TWMR_S_RACK; // RL8
							else
								new_code <= sda_f_reg ? `TWMR_S_WNACK : `TWMR_S_WACK; // RL19
							set_flag <= 1'b1;
							st_reg   <= twmr_pkg::TWMR_HOLD;
						end
					twmr_pkg::TWMR_RX:
						if (step_done) begin
							sh_reg  <= {sh_reg[6:0], sda_f_reg};
							bit_reg <= bit_reg + 3'h1;
							if (bit_reg == `TWMR_BIT_LAST)
								st_reg <= twmr_pkg::TWMR_ACKOUT;
						end
					twmr_pkg::TWMR_ACKOUT:
						if (step_done) begin
							if (lost) begin
								new_code  <= `TWMR_S_LOST;
								owner_reg <= 1'b0;
							end else begin
								new_code <= ctrl_reg.ack_en ? `TWMR_S_DACK : `TWMR_S_DNACK; // RL12
							end
							set_flag <= 1'b1;
							st_reg   <= twmr_pkg::TWMR_HOLD;
						end
					twmr_pkg::TWMR_HOLD:
						if (!ctrl_reg.flag && !set_flag) begin
							bit_reg <= 3'h0;
							if (ctrl_reg.halt_req && owner_reg)
								st_reg <= twmr_pkg::TWMR_STOP; // RL17
							else if (ctrl_reg.begin_req)
								st_reg <= owner_reg ? twmr_pkg::TWMR_START
									: twmr_pkg::TWMR_WAIT; // RL10
							else if (code_reg == `TWMR_S_START || code_reg == `TWMR_S_RSTART) begin
								sh_reg      <= data_reg; // RL7
								rd_mode_reg <= data_reg[0]; // RL19
								st_reg      <= twmr_pkg::TWMR_ADDR;
							end else if (code_reg == `TWMR_S_RACK || code_reg == `TWMR_S_DACK)
								st_reg <= twmr_pkg::TWMR_RX; // RL11
							else begin
								owner_reg <= 1'b0; // RL9
								st_reg    <= twmr_pkg::TWMR_IDLE;
							end
						end
					twmr_pkg::TWMR_STOP:
						if (step_done) begin
							owner_reg <= 1'b0;
							st_reg    <= ctrl_reg.begin_req ? twmr_pkg::TWMR_WAIT
								: twmr_pkg::TWMR_IDLE; // RL17
						end
					default:
						st_reg <= twmr_pkg::TWMR_IDLE;
				endcase
			end
		end
	end

	// control register; a hardware set of the flag wins over a clearing write
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg <= `TWMR_CTRL_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg.ack_en    <= reg_wdata[`TWMR_B_ACK];
				ctrl_reg.begin_req <= reg_wdata[`TWMR_B_BEGIN];
				ctrl_reg.enable    <= reg_wdata[`TWMR_B_EN]; // RL4
				ctrl_reg.int_en    <= reg_wdata[`TWMR_B_IE];
			end
			if (halt_done)
				ctrl_reg.halt_req <= 1'b0; // RL17
			else if (wr_ctrl)
				ctrl_reg.halt_req <= reg_wdata[`TWMR_B_HALT];
			if (set_flag)
				ctrl_reg.flag <= 1'b1;
			else if (!ctrl_reg.enable)
				ctrl_reg.flag <= 1'b0;
			else if (wr_ctrl && reg_wdata[`TWMR_B_FLAG] && !refuse)
				ctrl_reg.flag <= 1'b0; // RL4
			if (wr_data)
				ctrl_reg.wcol <= !ctrl_reg.flag;
		end
	end

	// status code and prescaler bits
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			code_reg <= `TWMR_S_NONE;
			pre_reg  <= 2'h0;
		end else begin
			if (set_flag)
				code_reg <= new_code;
			if (reg_wr && reg_addr == `TWMR_A_STAT)
				pre_reg <= reg_wdata[1:0];
		end
	end

	// data register: software loads only while the flag is set
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			data_reg <= `TWMR_DATA_RST;
		else if (st_reg == twmr_pkg::TWMR_ACKOUT && step_done)
			data_reg <= sh_reg; // RL12
		else if (wr_data && ctrl_reg.flag)
			data_reg <= reg_wdata;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`TWMR_A_CTRL: reg_rdata <= ctrl_reg;
				`TWMR_A_STAT: reg_rdata <= {code_reg[7:3], 1'b0, pre_reg}; // RL2
				`TWMR_A_DATA: reg_rdata <= data_reg;
				default:      reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	a_hold_scl_low: assert property ( // RL20
		st_reg == twmr_pkg::TWMR_HOLD && owner_reg |=> !scl_oen)
		else $error("clock not held low while flag set");
	a_start_code: assert property ( // RL6
		st_reg == twmr_pkg::TWMR_START && step_done |-> ##2 ctrl_reg.flag &&
		(code_reg == `TWMR_S_START || code_reg == `TWMR_S_RSTART))
		else $error("start did not report 08 or 10");
	a_addr_codes: assert property ( // RL8
		st_reg == twmr_pkg::TWMR_ACKIN && step_done && rd_mode_reg |-> ##2
		(code_reg == `TWMR_S_RACK || code_reg == `TWMR_S_RNACK))
		else $error("read address gave wrong code");
	a_rx_ack_code: assert property ( // RL12
		st_reg == twmr_pkg::TWMR_ACKOUT && step_done && !lost && !ctrl_reg.ack_en |-> ##2
		code_reg == `TWMR_S_DNACK && data_reg == $past(sh_reg, 2))
		else $error("nack byte not reported");
	a_disable_idle: assert property ( // RL4
		!ctrl_reg.enable |=> st_reg == twmr_pkg::TWMR_IDLE)
		else $error("disabled block left idle");
	a_wait_free_bus: assert property ( // RL5
		st_reg == twmr_pkg::TWMR_WAIT && busy_reg |=> st_reg != twmr_pkg::TWMR_START)
		else $error("start issued on busy bus");
	a_stop_halt_clear: assert property ( // RL17
		halt_done |=> !ctrl_reg.halt_req && !owner_reg)
		else $error("halt bit not cleared by stop");
	a_refuse_plain: assert property ( // RL14
		wr_ctrl && refuse && ctrl_reg.flag && ctrl_reg.enable |=> ctrl_reg.flag)
		else $error("plain resume accepted after nack");
	a_flag_set_wins: assert property ( // RL4
		set_flag && wr_ctrl |=> ctrl_reg.flag)
		else $error("flag set lost to clear");
endmodule

// *** test/twmr_slave.sv ***
// slave transmitter model on the two-wire bus
module twmr_slave #(
	parameter logic [6:0] SELF_ADDR = 7'h2a
) (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic [7:0] seed,
	output logic            sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh;
	logic       rd_dir;
	int         k;
	event       go;
	initial sda_low = 1'b0;
	// start or repeated start aborts and restarts the transaction
	// wires judged a moment later: the master moves data together with its clock fall
	always @(negedge sda) begin
		#1;
		if (scl === 1'b1) begin
			disable xfer;
			sda_low = 1'b0;
			#1 -> go;
		end
	end
	// stop releases the line
	always @(posedge sda) begin
		#1;
		if (scl === 1'b1) begin
			disable xfer;
			sda_low = 1'b0;
		end
	end
	always begin : xfer
		@(go);
		for (int i = 0; i < 8; i++) begin
			@(posedge scl);
			sh = {sh[6:0], sda};
		end
		@(negedge scl);
		rd_dir = sh[0];
		if (sh[7:1] == SELF_ADDR) begin
			sda_low = 1'b1;
			@(negedge scl);
			// a read hands the line straight to the first data bit
			if (!rd_dir)
				sda_low = 1'b0;
			k = 0;
			while (rd_dir) begin
				sh = seed + 8'(k * 8'h35);
				for (int i = 7; i >= 0; i--) begin
					sda_low = ~sh[i];
					@(negedge scl);
				end
				sda_low = 1'b0;
				@(posedge scl);
				// a nack from the master ends the read
				if (sda) break;
				k++;
				@(negedge scl);
			end
		end
	end
endmodule

// *** test/twmr_core_bench.sv ***
// self-checking bench for the two-wire master receiver
module twmr_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] SLV = 7'h2a;
	logic       core_clk;
	logic       resetn;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       sda_oen;
	logic       scl_oen;
	logic       s_low;
	logic       scl_w;
	logic       sda_w;
	logic       ext_low;
	logic [7:0] seed;
	logic [7:0] d;
	int         err_total;
	int         n_compared;
	int         exp_q[$];
	assign scl_w = scl_oen;
	assign sda_w = sda_oen & ~s_low & ~ext_low;
	twmr_core dut (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.sda_i     (sda_w),
		.sda_o     (),
		.sda_oen   (sda_oen),
		.scl_i     (scl_w),
		.scl_o     (),
		.scl_oen   (scl_oen)
	);
	twmr_slave #(.SELF_ADDR(SLV)) slave (
		.scl     (scl_w),
		.sda     (sda_w),
		.seed    (seed),
		.sda_low (s_low)
	);
	always #4 core_clk = ~core_clk;
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: register %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic chk_wire(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: wire %b, wanted %b", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// control writes on every cycle, back to back
	task automatic flood(input logic [7:0] v, input int n);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= 2'h0;
		reg_wdata <= v;
		repeat (n) @(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// poll the flag, then check the status code
	task automatic wait_flag(input logic [7:0] code);
		int n;
		n = 0;
		d = 8'h00;
		while (d[7] !== 1'b1 && n < 4000) begin
			rd(2'h0, d);
			n++;
		end
		if (n >= 4000) begin
			err_total++;
			$display("unexpected at %0t: flag never set", $time);
		end
		rd(2'h1, d);
		chk_reg(d & 8'hf8, code);
	endtask
	// resume with a control value, wait for the flag, check code and held clock
	task automatic step(input logic [7:0] ctl, input logic [7:0] code);
		wr(2'h0, ctl);
		wait_flag(code);
		repeat (400) @(posedge core_clk);
		chk_wire(scl_w, 1'b0);
	endtask
	initial begin
		#640_000;
		err_total++;
		$display("unexpected at %0t: watchdog expired", $time);
		summarize();
	end
	initial begin
		core_clk  = 1'b0;
		resetn    = 1'b0;
		reg_addr  = 2'h0;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		ext_low   = 1'b0;
		err_total = 0;
		n_compared = 0;
		void'($urandom(32739));
		seed = 8'($urandom);
		for (int k = 0; k < 3; k++) exp_q.push_back((seed + k * 8'h35) & 8'hff);
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		rd(2'h0, d);
		chk_reg(d, 8'h00);
		rd(2'h1, d);
		chk_reg(d, 8'hf8);
		rd(2'h2, d);
		chk_reg(d, 8'hff);
		rd(2'h3, d);
		chk_reg(d, 8'h00);
		wr(2'h1, 8'h03);
		rd(2'h1, d);
		chk_reg(d, 8'hfb);
		wr(2'h2, 8'h55);
		rd(2'h0, d);
		chk_reg(d & 8'h08, 8'h08);
		// start request without enable must stay idle
		wr(2'h0, 8'ha0);
		repeat (700) @(posedge core_clk);
		chk_wire(scl_w & sda_w, 1'b1);
		step(8'ha4, 8'h08);
		wr(2'h2, {SLV, 1'b1});
		rd(2'h0, d);
		chk_reg(d & 8'h08, 8'h00);
		step(8'hc4, 8'h40);
		for (int k = 0; k < 3; k++) begin
			if (k == 1) begin
				wr(2'h0, 8'hc4);
				// writes without the flag bit on every cycle, one meets the hardware set
				flood(8'h44, 3500);
			end
			step(k == 0 ? 8'hc4 : (k == 1 ? 8'h44 : 8'h84), k < 2 ? 8'h50 : 8'h58);
			rd(2'h2, d);
			chk_reg(d, 8'(exp_q.pop_front()));
		end
		step(8'hb4, 8'h08);
		rd(2'h0, d);
		chk_reg(d & 8'h10, 8'h00);
		wr(2'h2, {7'h13, 1'b1});
		step(8'h84, 8'h48);
		wr(2'h0, 8'h84);
		rd(2'h0, d);
		chk_reg(d & 8'h80, 8'h80);
		step(8'ha4, 8'h10);
		wr(2'h2, {SLV, 1'b0});
		step(8'h84, 8'h18);
		wr(2'h0, 8'h94);
		repeat (1500) @(posedge core_clk);
		rd(2'h0, d);
		chk_reg(d & 8'h10, 8'h00);
		chk_wire(scl_w & sda_w, 1'b1);
		// another master holds sda low: arbitration lost, start again once free
		step(8'ha4, 8'h08);
		wr(2'h2, {SLV, 1'b1});
		ext_low <= 1'b1;
		wr(2'h0, 8'h84);
		wait_flag(8'h38);
		wr(2'h0, 8'ha4);
		repeat (600) @(posedge core_clk);
		rd(2'h0, d);
		chk_reg(d & 8'h80, 8'h00);
		chk_wire(scl_w, 1'b1);
		ext_low <= 1'b0;
		wait_flag(8'h08);
		wr(2'h2, {SLV, 1'b1});
		ext_low <= 1'b1;
		wr(2'h0, 8'h84);
		wait_flag(8'h38);
		wr(2'h0, 8'h84);
		ext_low <= 1'b0;
		repeat (700) @(posedge core_clk);
		rd(2'h0, d);
		chk_reg(d & 8'h80, 8'h00);
		chk_wire(scl_w & sda_w, 1'b1);
		summarize();
	end
endmodule
